// file: rtl/isr_pkg.sv
package isr_pkg;

   localparam int REG_W = 16;
   localparam int BYTE_W = 8;
   localparam int SENSORS = 4;
   localparam int PIN_W = 14;

   // status byte bit positions
   localparam int STB_DEV_SUM = 1;
   localparam int STB_QUES_SUM = 3;
   localparam int STB_ESB = 5;

   // standard event bit positions
   localparam int EVT_OPC = 0;
   localparam int EVT_QYE = 2;
   localparam int EVT_DDE = 3;
   localparam int EVT_EXE = 4;
   localparam int EVT_CME = 5;
   localparam int EVT_URQ = 6;
   localparam int EVT_PON = 7;

   // questionable bit positions
   localparam int QUES_POWER = 3;
   localparam int QUES_WINDOW = 4;
   localparam int QUES_CAL = 8;
   localparam int QUES_SELF_TEST = 9;
   localparam int QUES_WARNING = 14;

   // bit that never carries information in 16-bit registers
   localparam logic [15:0] REG_USED_MASK = 16'h7FFF;

   localparam logic [7:0] EVT_RESET = 8'h80;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] REG_ZERO = 16'h0000;

   // error queue codes, two's complement
   localparam logic [15:0] ERR_CMD_CODE = 16'hFF9C;
   localparam logic [15:0] ERR_EXE_CODE = 16'hFF38;

   typedef enum logic [4:0] {
      CMD_IST_Q = 5'h00,
      CMD_PRE_W = 5'h01,
      CMD_PRE_Q = 5'h02,
      CMD_DEV_COND_Q = 5'h03,
      CMD_DEV_EVT_Q = 5'h04,
      CMD_DEV_ENA_W = 5'h05,
      CMD_DEV_ENA_Q = 5'h06,
      CMD_QUES_COND_Q = 5'h07,
      CMD_QUES_EVT_Q = 5'h08,
      CMD_QUES_ENA_W = 5'h09,
      CMD_QUES_ENA_Q = 5'h0A,
      CMD_EVT_Q = 5'h0B,
      CMD_EVT_ENA_W = 5'h0C,
      CMD_EVT_ENA_Q = 5'h0D,
      CMD_OPC = 5'h0E,
      CMD_STB_Q = 5'h0F
   } isr_cmd_type;

   typedef enum logic [1:0] {
      OPC_IDLE = 2'b01,
      OPC_WAIT = 2'b10
   } isr_opc_state_type;

   function automatic logic isr_is_known(input logic [4:0] code);
      isr_is_known = (code <= CMD_STB_Q);
   endfunction

   function automatic logic isr_is_query(input logic [4:0] code);
      isr_is_query = isr_is_known(code) && (code != CMD_PRE_W) && (code != CMD_DEV_ENA_W)
         && (code != CMD_QUES_ENA_W) && (code != CMD_EVT_ENA_W) && (code != CMD_OPC);
   endfunction

endpackage

// file: rtl/isr_stat_if.sv
`timescale 1ns/1ps
interface isr_stat_if;
   logic [isr_pkg::REG_W-1:0] cond;
   logic [isr_pkg::REG_W-1:0] en;
   logic rd_clr;
   logic [isr_pkg::REG_W-1:0] event_bits;
   logic summary;
   modport owner (output cond, output en, output rd_clr, input event_bits, input summary);
   modport regs (input cond, input en, input rd_clr, output event_bits, output summary);
endinterface

// file: rtl/isr_event_reg.sv
`timescale 1ns/1ps
module isr_event_reg (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // condition, enable and event view
   isr_stat_if.regs sr
);
   import isr_pkg::*;

   logic [REG_W-1:0] cond_d_reg;
   logic [REG_W-1:0] event_reg;
   logic [REG_W-1:0] event_next;
   logic [REG_W-1:0] rise;

   // positive transitions only; a new event in the read cycle survives the clear
   assign rise = sr.cond & ~cond_d_reg & REG_USED_MASK;
   assign event_next = (event_reg & ~{REG_W{sr.rd_clr}}) | rise;
   assign sr.event_bits = event_reg;
   assign sr.summary = |(event_reg & sr.en);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cond_d_reg <= REG_ZERO;
         event_reg <= REG_ZERO;
      end else begin
         cond_d_reg <= sr.cond;
         event_reg <= event_next;
      end
   end

endmodule

// file: rtl/isr_status_core.sv
`timescale 1ns/1ps
// Functional notes
// R1 - IST is OR of status byte bits ANDed with poll enable, bit 6 included.
// R2 - IST drives the parallel poll answer and the IST query.
// R3 - Poll enable mask written and read back by controller commands.
// R4 - Device status has condition and latched event parts, separately queried.
// R5 - Sensor presence bits 1,2,7,8; sensor error bits 3,4,9,10.
// R6 - Front/rear bits 5,6,11,12: zero front, one rear.
// R7 - Device bit 14: condition while key held, event once pressed.
// R8 - Bit 15 of device and questionable registers always reads zero.
// R9 - Questionable register flags out-of-spec states, condition and event queries.
// R10 - Questionable bits 3,4,8 carry power, window, calibration summaries.
// R11 - Questionable bit 9 set on power-up self-test failure.
// R12 - Standard event register is event-only, read by its query.
// R13 - Standard event enable mask is written and read back by commands.
// R14 - Event bit 0 set after operation-complete once prior commands finished.
// R15 - Event bit 2 on read without query or command over pending reply.
// R16 - Event bit 3 on device error; queue code -300..-399 or positive.
// R17 - Event bit 4 on execution error; queue code -200.
// R18 - Event bit 5 on unknown or malformed command; queue code -100.
// R19 - Event bit 6 when local key returns instrument to manual control.
// R20 - Event bit 7 set at power on.
// R21 - Reading an event register returns its contents then clears them.
// R22 - Summary bit is OR of event AND enable, feeding next higher register.
// R23 - Status byte bit 5 set while any enabled standard event is set.
// R24 - Status byte bit 1 carries the device status summary.
module isr_status_core (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // command port from the message parser
   input wire logic i_cmd_valid,
   input wire logic [4:0] i_cmd_code,
   input wire logic [isr_pkg::REG_W-1:0] i_cmd_data,
   input wire logic i_rsp_ack,
   output logic o_rsp_valid,
   output logic [isr_pkg::REG_W-1:0] o_rsp_data,
   // parser and executor events, same clock
   input wire logic i_read_no_query,
   input wire logic i_all_done,
   input wire logic i_dev_err,
   input wire logic [isr_pkg::REG_W-1:0] i_dev_err_code,
   input wire logic i_exec_err,
   input wire logic i_syntax_err,
   // lower-level summaries and status byte bits kept elsewhere, same clock
   input wire logic i_ques_power_sum,
   input wire logic i_ques_window_sum,
   input wire logic i_ques_cal_sum,
   input wire logic i_self_test_fail,
   input wire logic i_ques_warning,
   input wire logic [isr_pkg::BYTE_W-1:0] i_stb_ext,
   // sensor and panel pins, asynchronous
   input wire logic [isr_pkg::SENSORS-1:0] i_sensor_present,
   input wire logic [isr_pkg::SENSORS-1:0] i_sensor_error,
   input wire logic [isr_pkg::SENSORS-1:0] i_sensor_rear,
   input wire logic i_key_held,
   input wire logic i_local_key,
   // status outputs
   output logic o_ist,
   output logic [isr_pkg::BYTE_W-1:0] o_stb,
   output logic o_err_push,
   output logic [isr_pkg::REG_W-1:0] o_err_code
);
   import isr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s1_reg;
   logic [PIN_W-1:0] pin_s2_reg;
   logic [PIN_W-1:0] pin_s3_reg;
   logic [PIN_W-1:0] pin_reg;
   logic [PIN_W-1:0] pin_next;

   assign pin_raw = {i_local_key, i_key_held, i_sensor_rear, i_sensor_error, i_sensor_present};
   // a bit only moves when the second and third stages agree
   assign pin_next = (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg ^ pin_s3_reg));

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
         pin_reg <= '0;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_reg <= pin_next;
      end
   end

   logic [SENSORS-1:0] pres;
   logic [SENSORS-1:0] serr;
   logic [SENSORS-1:0] rear;
   logic key_held;
   logic local_key;

   assign pres = pin_reg[3:0];
   assign serr = pin_reg[7:4];
   assign rear = pin_reg[11:8];
   assign key_held = pin_reg[12];
   assign local_key = pin_reg[13];

   ////////////////////////////////////////////////////////////////////////////////
   // device and questionable registers

   isr_stat_if dev_if ();
   isr_stat_if ques_if ();

   logic [REG_W-1:0] dev_en_reg;
   logic [REG_W-1:0] ques_en_reg;
   logic cmd_known;
   logic cmd_query;
   logic take_wr;

   assign cmd_known = isr_is_known(i_cmd_code);
   assign cmd_query = isr_is_query(i_cmd_code);
   assign take_wr = i_cmd_valid && cmd_known;

   // bit 0, 13 and 15 unused
   assign dev_if.cond = {1'b0, key_held, 1'b0, rear[3], rear[2], serr[3], serr[2],
      pres[3], pres[2], rear[1], rear[0], serr[1], serr[0], pres[1], pres[0], 1'b0}; // [R5] [R6] [R7]
   assign dev_if.en = dev_en_reg;
   assign dev_if.rd_clr = take_wr && (i_cmd_code == CMD_DEV_EVT_Q); // [R4] [R21]

   always_comb begin
      ques_if.cond = REG_ZERO;
      ques_if.cond[QUES_POWER] = i_ques_power_sum; // [R10]
      ques_if.cond[QUES_WINDOW] = i_ques_window_sum; // [R10]
      ques_if.cond[QUES_CAL] = i_ques_cal_sum; // [R10]
      ques_if.cond[QUES_SELF_TEST] = i_self_test_fail; // [R11]
      ques_if.cond[QUES_WARNING] = i_ques_warning; // [R9]
   end
   assign ques_if.en = ques_en_reg;
   assign ques_if.rd_clr = take_wr && (i_cmd_code == CMD_QUES_EVT_Q); // [R9] [R21]

   isr_event_reg u_dev_reg (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .sr(dev_if.regs)
   );

   isr_event_reg u_ques_reg (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .sr(ques_if.regs)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // standard event register and operation complete

   isr_opc_state_type opc_state_reg;
   isr_opc_state_type opc_state_next;
   logic [BYTE_W-1:0] std_evt_reg;
   logic [BYTE_W-1:0] std_evt_set;
   logic [BYTE_W-1:0] std_evt_next;
   logic [BYTE_W-1:0] std_en_reg;
   logic [BYTE_W-1:0] poll_en_reg;
   logic local_d_reg;
   logic opc_hit;
   logic query_err;
   logic syntax_err;
   logic std_evt_clr;

   always_comb begin
      opc_state_next = opc_state_reg;
      case (opc_state_reg)
         OPC_IDLE: begin
            if (take_wr && (i_cmd_code == CMD_OPC)) begin
               opc_state_next = OPC_WAIT;
            end
         end
         OPC_WAIT: begin
            if (i_all_done) begin
               opc_state_next = OPC_IDLE;
            end
         end
         default: begin
            opc_state_next = OPC_IDLE;
         end
      endcase
   end

   assign opc_hit = (opc_state_reg == OPC_WAIT) && i_all_done; // [R14]
   // a new command while a reply is still unread discards that reply
   assign query_err = i_read_no_query || (i_cmd_valid && o_rsp_valid && !i_rsp_ack); // [R15]
   assign syntax_err = i_syntax_err || (i_cmd_valid && !cmd_known); // [R18]
   assign std_evt_clr = take_wr && (i_cmd_code == CMD_EVT_Q); // [R12] [R21]

   always_comb begin
      std_evt_set = BYTE_ZERO;
      std_evt_set[EVT_OPC] = opc_hit; // [R14]
      std_evt_set[EVT_QYE] = query_err; // [R15]
      std_evt_set[EVT_DDE] = i_dev_err; // [R16]
      std_evt_set[EVT_EXE] = i_exec_err; // [R17]
      std_evt_set[EVT_CME] = syntax_err; // [R18]
      std_evt_set[EVT_URQ] = local_key && !local_d_reg; // [R19]
   end
   // set beats the read clear in the same cycle
   assign std_evt_next = (std_evt_reg & ~{BYTE_W{std_evt_clr}}) | std_evt_set; // [R21]

   ////////////////////////////////////////////////////////////////////////////////
   // status byte, IST and error queue push

   logic [BYTE_W-1:0] stb_next;
   logic ist_next;
   logic err_push_next;
   logic [REG_W-1:0] err_code_next;

   always_comb begin
      stb_next = i_stb_ext;
      stb_next[STB_DEV_SUM] = dev_if.summary; // [R22] [R24]
      stb_next[STB_QUES_SUM] = ques_if.summary; // [R22]
      stb_next[STB_ESB] = |(std_evt_reg & std_en_reg); // [R13] [R22] [R23]
   end
   // unlike the service request mask, bit 6 takes part here
   assign ist_next = |(stb_next & poll_en_reg); // [R1]

   assign err_push_next = syntax_err || i_exec_err || i_dev_err;
   // one code per cycle; the parser is the earliest stage so it wins
   assign err_code_next = syntax_err ? ERR_CMD_CODE : // [R18]
      i_exec_err ? ERR_EXE_CODE : i_dev_err_code; // [R16] [R17]

   ////////////////////////////////////////////////////////////////////////////////
   // query answers

   logic [REG_W-1:0] rsp_sel;

   always_comb begin
      rsp_sel = REG_ZERO;
      case (i_cmd_code)
         CMD_IST_Q: rsp_sel = {15'h0, o_ist}; // [R2]
         CMD_PRE_Q: rsp_sel = {8'h00, poll_en_reg}; // [R3]
         CMD_DEV_COND_Q: rsp_sel = dev_if.cond & REG_USED_MASK; // [R4] [R8]
         CMD_DEV_EVT_Q: rsp_sel = dev_if.event_bits & REG_USED_MASK; // [R4] [R8]
         CMD_DEV_ENA_Q: rsp_sel = dev_en_reg;
         CMD_QUES_COND_Q: rsp_sel = ques_if.cond & REG_USED_MASK; // [R8] [R9]
         CMD_QUES_EVT_Q: rsp_sel = ques_if.event_bits & REG_USED_MASK; // [R8] [R9]
         CMD_QUES_ENA_Q: rsp_sel = ques_en_reg;
         CMD_EVT_Q: rsp_sel = {8'h00, std_evt_reg}; // [R12]
         CMD_EVT_ENA_Q: rsp_sel = {8'h00, std_en_reg}; // [R13]
         CMD_STB_Q: rsp_sel = {8'h00, o_stb};
         default: rsp_sel = REG_ZERO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         opc_state_reg <= OPC_IDLE;
         std_evt_reg <= EVT_RESET; // [R20]
         std_en_reg <= BYTE_ZERO;
         poll_en_reg <= BYTE_ZERO;
         dev_en_reg <= REG_ZERO;
         ques_en_reg <= REG_ZERO;
         local_d_reg <= 1'b0;
         o_stb <= BYTE_ZERO;
         o_ist <= 1'b0;
         o_err_push <= 1'b0;
         o_err_code <= REG_ZERO;
      end else begin
         opc_state_reg <= opc_state_next;
         std_evt_reg <= std_evt_next;
         local_d_reg <= local_key;
         o_stb <= stb_next;
         o_ist <= ist_next; // [R2]
         o_err_push <= err_push_next;
         o_err_code <= err_code_next;
         if (take_wr && (i_cmd_code == CMD_PRE_W)) begin
            poll_en_reg <= i_cmd_data[BYTE_W-1:0]; // [R3]
         end
         if (take_wr && (i_cmd_code == CMD_EVT_ENA_W)) begin
            std_en_reg <= i_cmd_data[BYTE_W-1:0]; // [R13]
         end
         if (take_wr && (i_cmd_code == CMD_DEV_ENA_W)) begin
            dev_en_reg <= i_cmd_data & REG_USED_MASK;
         end
         if (take_wr && (i_cmd_code == CMD_QUES_ENA_W)) begin
            ques_en_reg <= i_cmd_data & REG_USED_MASK;
         end
      end
   end

   // answer stands until acknowledged, replaced by the next query, or dropped by any other command
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rsp_valid <= 1'b0;
         o_rsp_data <= REG_ZERO;
      end else if (i_cmd_valid && cmd_query) begin
         o_rsp_valid <= 1'b1;
         o_rsp_data <= rsp_sel;
      end else if (i_cmd_valid || i_rsp_ack) begin
         o_rsp_valid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   a_ist_poll_mask: assert property ( // [R1]
      ##1 o_ist == |(o_stb & $past(poll_en_reg)))
      else $error("ist flag does not match status byte and poll mask");

   a_pre_write_read: assert property ( // [R3]
      (i_cmd_valid && i_cmd_code == CMD_PRE_W) ##1 !i_cmd_valid
      ##1 (i_cmd_valid && i_cmd_code == CMD_PRE_Q)
      |=> o_rsp_valid && o_rsp_data == {8'h00, $past(i_cmd_data[7:0], 3)})
      else $error("poll enable read back differs from written value");

   a_event_read_clear: assert property ( // [R21]
      (i_cmd_valid && i_cmd_code == CMD_EVT_Q && std_evt_set == BYTE_ZERO)
      |=> o_rsp_data == {8'h00, $past(std_evt_reg)} && std_evt_reg == BYTE_ZERO)
      else $error("event query did not return and clear contents");

   a_bit15_zero: assert property ( // [R8]
      o_rsp_valid |-> !o_rsp_data[15])
      else $error("bit 15 read as one");

   a_esb_summary: assert property ( // [R23]
      ##1 o_stb[STB_ESB] == |($past(std_evt_reg) & $past(std_en_reg)))
      else $error("status byte bit 5 wrong");

   a_opc_complete: assert property ( // [R14]
      (opc_state_reg == OPC_WAIT && i_all_done) |=> std_evt_reg[EVT_OPC] && opc_state_reg == OPC_IDLE)
      else $error("operation complete not latched");

   a_cmd_err_code: assert property ( // [R18]
      (i_cmd_valid && !cmd_known)
      |=> o_err_push && o_err_code == ERR_CMD_CODE && std_evt_reg[EVT_CME])
      else $error("unknown command not reported");

   a_query_overrun: assert property ( // [R15]
      (i_cmd_valid && o_rsp_valid && !i_rsp_ack) |=> std_evt_reg[EVT_QYE])
      else $error("pending reply overrun not flagged");

endmodule

// file: sim/isr_ctl_model.sv
`timescale 1ns/1ps
module isr_ctl_model
   import isr_pkg::*;
(
   // clock
   input wire logic i_clk,
   // answer from the device
   input wire logic i_rsp_valid,
   input wire logic [isr_pkg::REG_W-1:0] i_rsp_data,
   // command side
   output logic o_cmd_valid,
   output logic [4:0] o_cmd_code,
   output logic [isr_pkg::REG_W-1:0] o_cmd_data,
   output logic o_rsp_ack
);
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_code = 5'h1F;
      o_cmd_data = REG_ZERO;
      o_rsp_ack = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // mask writes and reads go through here
   task automatic issue(input logic [4:0] code, input logic [15:0] data);
      @(negedge i_clk);
      o_cmd_valid = 1'b1;
      o_cmd_code = code;
      o_cmd_data = data;
      @(negedge i_clk);
      o_cmd_valid = 1'b0;
      // released lines flip so a stale value never looks valid
      o_cmd_code = ~code;
      o_cmd_data = ~data;
   endtask

   // ack low leaves the answer pending on purpose
   task automatic query(input logic [4:0] code, input logic ack, output logic [15:0] d);
      int n;
      n = 0;
      issue(code, REG_ZERO);
      while (i_rsp_valid !== 1'b1 && n < 4) begin
         @(negedge i_clk);
         n++;
      end
      d = (i_rsp_valid === 1'b1) ? i_rsp_data : 16'hXXXX;
      if (ack) begin
         o_rsp_ack = 1'b1;
         @(negedge i_clk);
         o_rsp_ack = 1'b0;
      end
   endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
      end \
   end
module tb_top;
   import isr_pkg::*;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_cmd_valid, i_rsp_ack, o_rsp_valid, o_ist, o_err_push;
   logic [4:0] i_cmd_code;
   logic [15:0] i_cmd_data, o_rsp_data, o_err_code;
   logic i_read_no_query = 0, i_all_done = 0, i_dev_err = 0, i_exec_err = 0;
   logic i_syntax_err = 0, i_ques_power_sum = 0, i_ques_window_sum = 0;
   logic i_ques_cal_sum = 0, i_self_test_fail = 0, i_ques_warning = 0;
   logic i_key_held = 0, i_local_key = 0;
   logic [15:0] i_dev_err_code = 16'h0000;
   logic [7:0] i_stb_ext = 8'h00;
   logic [7:0] o_stb;
   logic [3:0] i_sensor_present = 0, i_sensor_error = 0, i_sensor_rear = 0;
   logic [15:0] pushq[$];
   int err_count = 0;
   int checks_done = 0;

   always #20 i_clk = ~i_clk;

   isr_status_core isr_status_core_i (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_cmd_data(i_cmd_data),
      .i_rsp_ack(i_rsp_ack), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
      .i_read_no_query(i_read_no_query), .i_all_done(i_all_done), .i_dev_err(i_dev_err),
      .i_dev_err_code(i_dev_err_code), .i_exec_err(i_exec_err),
      .i_syntax_err(i_syntax_err), .i_ques_power_sum(i_ques_power_sum),
      .i_ques_window_sum(i_ques_window_sum), .i_ques_cal_sum(i_ques_cal_sum),
      .i_self_test_fail(i_self_test_fail), .i_ques_warning(i_ques_warning),
      .i_stb_ext(i_stb_ext), .i_sensor_present(i_sensor_present),
      .i_sensor_error(i_sensor_error), .i_sensor_rear(i_sensor_rear),
      .i_key_held(i_key_held), .i_local_key(i_local_key), .o_ist(o_ist), .o_stb(o_stb),
      .o_err_push(o_err_push), .o_err_code(o_err_code));

   isr_ctl_model isr_ctl_model_i (.i_clk(i_clk), .i_rsp_valid(o_rsp_valid),
      .i_rsp_data(o_rsp_data), .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code),
      .o_cmd_data(i_cmd_data), .o_rsp_ack(i_rsp_ack));

   // push is a one-cycle pulse, so log it on every edge
   always @(posedge i_clk) begin
      if (o_err_push === 1'b1) pushq.push_back(o_err_code);
   end

   ////////////////////////////////////////////////////////////
   task automatic wait_n(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic rd_chk(input string what, input logic [4:0] code, input logic [15:0] exp);
      logic [15:0] d;
      isr_ctl_model_i.query(code, 1'b1, d);
      `CHK(what, exp, d)
   endtask

   task automatic t_reset;
      rd_chk("event power on", CMD_EVT_Q, 16'h0080);
      rd_chk("event cleared", CMD_EVT_Q, 16'h0000);
      rd_chk("event enable reset", CMD_EVT_ENA_Q, 16'h0000);
      rd_chk("pre reset", CMD_PRE_Q, 16'h0000);
   endtask

   task automatic t_masks;
      isr_ctl_model_i.issue(CMD_PRE_W, 16'hFF3C);
      rd_chk("pre readback", CMD_PRE_Q, 16'h003C);
      isr_ctl_model_i.issue(CMD_EVT_ENA_W, 16'h005A);
      rd_chk("event enable readback", CMD_EVT_ENA_Q, 16'h005A);
   endtask

   task automatic t_ist;
      @(negedge i_clk) i_stb_ext = 8'h40;
      isr_ctl_model_i.issue(CMD_PRE_W, 16'h0040);
      wait_n(3);
      `CHK("ist bit6", 1'b1, o_ist)
      rd_chk("ist query set", CMD_IST_Q, 16'h0001);
      rd_chk("stb query", CMD_STB_Q, 16'h0040);
      isr_ctl_model_i.issue(CMD_PRE_W, 16'h00BF);
      wait_n(3);
      `CHK("ist masked", 1'b0, o_ist)
      rd_chk("ist query clr", CMD_IST_Q, 16'h0000);
      @(negedge i_clk) i_stb_ext = 8'h00;
   endtask

   task automatic t_device;
      @(negedge i_clk);
      i_sensor_present = 4'b0101;
      i_sensor_error = 4'b1010;
      i_sensor_rear = 4'b0110;
      i_key_held = 1'b1;
      wait_n(8);
      rd_chk("dev cond", CMD_DEV_COND_Q, 16'h4CD2);
      rd_chk("dev event", CMD_DEV_EVT_Q, 16'h4CD2);
      rd_chk("dev event clr", CMD_DEV_EVT_Q, 16'h0000);
      isr_ctl_model_i.issue(CMD_DEV_ENA_W, 16'hC000);
      rd_chk("dev enable", CMD_DEV_ENA_Q, 16'h4000);
      `CHK("dev sum idle", 1'b0, o_stb[STB_DEV_SUM])
      @(negedge i_clk) i_key_held = 1'b0;
      wait_n(8);
      @(negedge i_clk) i_key_held = 1'b1;
      wait_n(8);
      `CHK("dev sum key", 1'b1, o_stb[STB_DEV_SUM])
      rd_chk("dev key event", CMD_DEV_EVT_Q, 16'h4000);
      wait_n(2);
      `CHK("dev sum clr", 1'b0, o_stb[STB_DEV_SUM])
   endtask

   task automatic t_ques;
      @(negedge i_clk);
      {i_ques_power_sum, i_ques_window_sum, i_ques_cal_sum} = 3'b111;
      {i_self_test_fail, i_ques_warning} = 2'b11;
      wait_n(3);
      rd_chk("ques cond", CMD_QUES_COND_Q, 16'h4318);
      rd_chk("ques event", CMD_QUES_EVT_Q, 16'h4318);
      isr_ctl_model_i.issue(CMD_QUES_ENA_W, 16'hFFFF);
      rd_chk("ques enable", CMD_QUES_ENA_Q, 16'h7FFF);
      `CHK("ques sum idle", 1'b0, o_stb[STB_QUES_SUM])
      @(negedge i_clk) i_ques_power_sum = 1'b0;
      wait_n(2);
      @(negedge i_clk) i_ques_power_sum = 1'b1;
      wait_n(3);
      `CHK("ques sum", 1'b1, o_stb[STB_QUES_SUM])
   endtask

   task automatic t_esr;
      isr_ctl_model_i.issue(CMD_EVT_ENA_W, 16'h007D);
      isr_ctl_model_i.issue(CMD_OPC, 16'h0000);
      wait_n(3);
      `CHK("esb before done", 1'b0, o_stb[STB_ESB])
      @(negedge i_clk) i_all_done = 1'b1;
      @(negedge i_clk) i_all_done = 1'b0;
      @(negedge i_clk) i_read_no_query = 1'b1;
      @(negedge i_clk) i_read_no_query = 1'b0;
      i_dev_err = 1'b1;
      i_dev_err_code = 16'hFED4;
      @(negedge i_clk) i_dev_err = 1'b0;
      i_exec_err = 1'b1;
      @(negedge i_clk) i_exec_err = 1'b0;
      i_syntax_err = 1'b1;
      @(negedge i_clk) i_syntax_err = 1'b0;
      isr_ctl_model_i.issue(5'h10, 16'h0000);
      @(negedge i_clk) i_local_key = 1'b1;
      wait_n(8);
      i_local_key = 1'b0;
      wait_n(2);
      `CHK("esb set", 1'b1, o_stb[STB_ESB])
      rd_chk("std events", CMD_EVT_Q, 16'h007D);
      wait_n(2);
      `CHK("esb clr", 1'b0, o_stb[STB_ESB])
      `CHK("push count", 4, pushq.size())
      `CHK("push dev", 16'hFED4, pushq[0])
      `CHK("push exec", ERR_EXE_CODE, pushq[1])
      `CHK("push syntax", ERR_CMD_CODE, pushq[2])
      `CHK("push unknown", ERR_CMD_CODE, pushq[3])
   endtask

   task automatic t_pending;
      logic [15:0] d;
      isr_ctl_model_i.query(CMD_EVT_ENA_Q, 1'b0, d);
      `CHK("enable pending", 16'h007D, d)
      wait_n(1);
      `CHK("reply stands", 1'b1, o_rsp_valid)
      rd_chk("pre after drop", CMD_PRE_Q, 16'h00BF);
      rd_chk("query error event", CMD_EVT_Q, 16'h0004);
   endtask

   ////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(negedge i_clk);
      i_rstn = 1'b1;
      t_reset();
      t_masks();
      t_ist();
      t_device();
      t_ques();
      t_esr();
      t_pending();
      stop_test();
   end

   // whole run is under 200 cycles
   initial begin
      repeat (5000) @(posedge i_clk);
      err_count++;
      stop_test();
   end
endmodule
